// File: rtl/ivd_top.sv
/*
  interrupt priority arbiter and vector dispatch of an 8-bit core, with an
  ahb-lite register slave, external pin edge detection and event interrupt.
  assumes the core sequencer and program memory run on hclk; the external
  pin is asynchronous; peripheral pending lines are synchronous to hclk.
*/
// Contract
// - dispatch instruction starts arbitration over all active sources by fixed rank
// - arbiter yields an even byte from e0 to fe for the top source
// - selection uses state of the first dispatch cycle only
// - active software trap always yields fe
// - external interrupt without trap yields fa; lower ranks lower even values
// - offset replaces only the low pc byte, upper byte kept unless the low byte is ff
// - vector read from program memory is loaded into the pc
// - nmi pending cleared by clear instruction and by reset
// - edge select set makes the external pin trigger on falling edge
// - software clears external pending; return instruction sets global enable
// - nothing enabled and pending selects the default e0 entry
// - vector is 15 bits, high byte at the lower address
// - entries rise by two bytes with rank, skipping f0 and fc; trap always at fe/ff
// - dispatch at last address of a block takes table from next block
`timescale 1ns/100ps
`include "ivd_cfg.svh"

module ivd_top
  import ivd_pkg::*;
#(
  parameter int NPER = 11
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core instruction strobes
  input wire logic vector_dispatch_instruction,
  input wire logic [14:0] dispatch_pc,
  input wire logic clear_nmi_pending_instruction,
  input wire logic trap_instruction,
  input wire logic interrupt_return_instruction,
  input wire logic int_taken,
  // program counter load
  output logic pc_load,
  output logic [14:0] pc_value,
  output logic dispatch_busy,
  // program memory read port
  output logic pm_req,
  output logic [14:0] pm_addr,
  input wire logic [7:0] pm_rdata,
  input wire logic pm_ack,
  // interrupt sources
  input wire logic ext_pin,
  input wire logic [NPER-1:0] periph_pend,
  // requests
  output logic core_int_req,
  output logic irq
);

  // ========================================================================
  // state
  typedef struct packed {
    ivd_state_t state;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [2:0] ext_fill; // pin pipeline refill count after reset
    logic global_int_enable;
    logic ext_edge_select;
    logic ext_en;
    logic ext_int_pending;
    logic nmi_pending;
    logic [NPER-1:0] per_en;
    logic [3:0] stat;
    logic [3:0] mask;
    logic [7:0] sel_off;
    logic [6:0] tbl_blk;
    logic [6:0] vec_hi;
    logic [14:0] pc_value;
    logic pc_load;
    logic [7:0] last_off;
    logic [14:0] last_vec;
    logic wr_pend;
    logic [4:0] wr_ofs;
    logic [31:0] hrdata;
  } ivd_regs_t;

  ivd_regs_t q_r;
  ivd_regs_t q_nxt;

  // slot table cut to the number of peripheral lines actually built
  localparam logic [8*NPER-1:0] SLOT_OFFS = (8*NPER)'(`IVD_SLOT_OFFS);

  // ========================================================================
  // arbitration
  logic ext_edge;
  logic ext_act;
  logic [NPER-1:0] per_act;
  logic [7:0] arb_off;
  logic ahb_take;
  logic [4:0] a_ofs;

  // pin edge seen only after the second synchroniser stage; the detector is
  // held off until the pipeline has refilled after reset, so a pin that
  // idles high does not fake a rising edge
  always_comb begin
    ext_edge = 1'b0;
    if (q_r.ext_fill[2]) begin
      if (q_r.ext_edge_select) begin
        ext_edge = q_r.ext_prev & ~q_r.ext_sync[1];
      end else begin
        ext_edge = ~q_r.ext_prev & q_r.ext_sync[1];
      end
    end
  end

  assign ext_act = q_r.ext_en & q_r.ext_int_pending;
  assign per_act = q_r.per_en & periph_pend;

  // global enable is ignored here: the dispatcher runs inside the service
  // routine, where global enable has already been dropped by the core
  // fixed rank, trap first; scan lowest rank upward so highest wins
  always_comb begin
    arb_off = `IVD_VEC_DFLT;
    for (int i = NPER - 1; i >= 0; i--) begin
      if (per_act[i]) begin
        arb_off = SLOT_OFFS[8*(NPER-1-i) +: 8];
      end
    end
    if (ext_act) begin
      arb_off = `IVD_VEC_EXT;
    end
    if (q_r.nmi_pending) begin
      arb_off = `IVD_VEC_TRAP;
    end
  end

  assign ahb_take = hsel & htrans[1] & hready;
  assign a_ofs = haddr[4:0];

  // ========================================================================
  // next state
  always_comb begin
    q_nxt = q_r;
    q_nxt.pc_load = 1'b0;
    q_nxt.ext_sync = {q_r.ext_sync[0], ext_pin};
    q_nxt.ext_prev = q_r.ext_sync[1];
    q_nxt.ext_fill = {q_r.ext_fill[1:0], 1'b1}; // arms the edge detector

    // dispatch sequencer
    // a dispatch pulse outside idle is dropped without notice; the core never
    // issues one while the previous vector fetch is still running
    case (q_r.state)
      IVD_IDLE: begin
        if (vector_dispatch_instruction) begin
          // decision frozen here; later source changes are ignored
          q_nxt.sel_off = arb_off;
          if (dispatch_pc[7:0] == 8'hff) begin
            q_nxt.tbl_blk = dispatch_pc[14:8] + 7'h01;
          end else begin
            q_nxt.tbl_blk = dispatch_pc[14:8];
          end
          q_nxt.state = IVD_RD_HI;
        end
      end
      IVD_RD_HI: begin
        if (pm_ack) begin
          q_nxt.vec_hi = pm_rdata[6:0];
          q_nxt.state = IVD_RD_LO;
        end
      end
      IVD_RD_LO: begin
        if (pm_ack) begin
          q_nxt.pc_value = {q_r.vec_hi, pm_rdata};
          q_nxt.state = IVD_LOAD;
        end
      end
      IVD_LOAD: begin
        q_nxt.pc_load = 1'b1;
        q_nxt.last_off = q_r.sel_off;
        q_nxt.last_vec = q_r.pc_value;
        q_nxt.state = IVD_IDLE;
      end
      default: begin
        q_nxt.state = IVD_IDLE;
      end
    endcase

    // ahb data phase of a write
    // the slave never stalls, so the word lands at the edge closing the data
    // phase and is readable from the following address phase on
    q_nxt.wr_pend = ahb_take & hwrite;
    if (ahb_take) begin
      q_nxt.wr_ofs = a_ofs;
    end
    if (q_r.wr_pend) begin
      case (q_r.wr_ofs)
        `IVD_OFS_CTRL: begin
          q_nxt.global_int_enable = hwdata[`IVD_CTRL_GIE];
          q_nxt.ext_edge_select = hwdata[`IVD_CTRL_EDGE];
          q_nxt.ext_en = hwdata[`IVD_CTRL_EXTEN];
        end
        `IVD_OFS_PEND: begin
          if (hwdata[`IVD_PEND_EXT]) begin
            q_nxt.ext_int_pending = 1'b0;
          end
        end
        `IVD_OFS_PEN: begin
          q_nxt.per_en = hwdata[NPER-1:0];
        end
        `IVD_OFS_STAT: begin
          q_nxt.stat = q_r.stat & ~hwdata[3:0];
        end
        `IVD_OFS_MASK: begin
          q_nxt.mask = hwdata[3:0];
        end
        default: begin
          q_nxt.mask = q_r.mask;
        end
      endcase
    end

    // global enable: taken interrupt clears, return sets (return wins)
    // a return that overlaps a new entry thus leaves interrupts enabled,
    // so a nested return through the dispatcher is not lost
    if (int_taken) begin
      q_nxt.global_int_enable = 1'b0;
    end
    if (interrupt_return_instruction) begin
      q_nxt.global_int_enable = 1'b1;
    end

    // pending flags: hardware set beats any clear in the same cycle
    // a clear instruction that meets a new trap leaves the flag set, so a
    // trap raised inside its own service routine is never dropped
    if (clear_nmi_pending_instruction) begin
      q_nxt.nmi_pending = 1'b0;
    end
    if (trap_instruction) begin
      q_nxt.nmi_pending = 1'b1;
    end
    if (ext_edge) begin
      q_nxt.ext_int_pending = 1'b1;
    end

    // sticky events, set wins over write-one-to-clear
    if (ext_edge) begin
      q_nxt.stat[`IVD_EV_EXT] = 1'b1;
    end
    if (trap_instruction) begin
      q_nxt.stat[`IVD_EV_TRAP] = 1'b1;
    end
    if (q_r.state == IVD_LOAD) begin
      q_nxt.stat[`IVD_EV_DONE] = 1'b1;
      if (q_r.sel_off == `IVD_VEC_DFLT) begin
        q_nxt.stat[`IVD_EV_DFLT] = 1'b1;
      end
    end

    // read data captured in the address phase, unmapped reads zero
    // a read right behind a write to the same word still returns the old
    // value; software that needs the new one leaves a transfer between them
    // in exchange the slave answers with no wait state at all
    q_nxt.hrdata = 32'h0000_0000;
    if (ahb_take & ~hwrite) begin
      case (a_ofs)
        `IVD_OFS_CTRL: begin
          q_nxt.hrdata[`IVD_CTRL_GIE] = q_r.global_int_enable;
          q_nxt.hrdata[`IVD_CTRL_EDGE] = q_r.ext_edge_select;
          q_nxt.hrdata[`IVD_CTRL_EXTEN] = q_r.ext_en;
        end
        `IVD_OFS_PEND: begin
          q_nxt.hrdata[`IVD_PEND_EXT] = q_r.ext_int_pending;
          q_nxt.hrdata[`IVD_PEND_NMI] = q_r.nmi_pending;
        end
        `IVD_OFS_PEN: begin
          q_nxt.hrdata[NPER-1:0] = q_r.per_en;
        end
        `IVD_OFS_STAT: begin
          q_nxt.hrdata[3:0] = q_r.stat;
        end
        `IVD_OFS_MASK: begin
          q_nxt.hrdata[3:0] = q_r.mask;
        end
        `IVD_OFS_LAST: begin
          q_nxt.hrdata[7:0] = q_r.last_off;
          q_nxt.hrdata[30:16] = q_r.last_vec;
        end
        default: begin
          q_nxt.hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ========================================================================
  // registers; reset also clears the nmi pending flag
  // every field resets to zero except the ones named below
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= '0;
      q_r.state <= IVD_IDLE;
      q_r.mask <= `IVD_MASK_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ========================================================================
  // outputs
  assign hreadyout = 1'b1; // zero wait states, always okay
  assign hresp = 1'b0;
  assign hrdata = q_r.hrdata;
  assign pc_load = q_r.pc_load;
  assign pc_value = q_r.pc_value;
  assign dispatch_busy = (q_r.state != IVD_IDLE);

  // table entry: only the low pc byte is replaced by the offset
  // request and address stand until acknowledged, so the program memory may
  // insert any number of wait states
  always_comb begin
    pm_req = (q_r.state == IVD_RD_HI) | (q_r.state == IVD_RD_LO);
    if (q_r.state == IVD_RD_LO) begin
      pm_addr = {q_r.tbl_blk, q_r.sel_off | 8'h01};
    end else begin
      pm_addr = {q_r.tbl_blk, q_r.sel_off};
    end
  end

  // trap requests regardless of global enable; maskable ones need it
  // the level drops as soon as the pending or enable bits are cleared
  assign core_int_req = q_r.nmi_pending |
    (q_r.global_int_enable & (ext_act | (|per_act)));
  assign irq = |(q_r.stat & q_r.mask);

endmodule : ivd_top

// File: rtl/ivd_cfg.svh
/*
  constants of the interrupt vector dispatch block: register byte offsets,
  reset values, field positions and vector table offsets.
  assumes it is included by bare name from the top module and the testbench.
*/
`ifndef IVD_CFG_SVH
`define IVD_CFG_SVH
// ==========================================================================
// register byte offsets (one aligned 32-bit word each)
`define IVD_OFS_CTRL 5'h00
`define IVD_OFS_PEND 5'h04
`define IVD_OFS_PEN 5'h08
`define IVD_OFS_STAT 5'h0c
`define IVD_OFS_MASK 5'h10
`define IVD_OFS_LAST 5'h14
// ==========================================================================
// control register fields and reset value
`define IVD_CTRL_GIE 0
`define IVD_CTRL_EDGE 1
`define IVD_CTRL_EXTEN 2
`define IVD_CTRL_RST 3'h0
// pending register fields
`define IVD_PEND_EXT 0
`define IVD_PEND_NMI 1
// status / mask event bits
`define IVD_EV_EXT 0
`define IVD_EV_TRAP 1
`define IVD_EV_DONE 2
`define IVD_EV_DFLT 3
`define IVD_MASK_RST 4'h0
// ==========================================================================
// vector table low-byte offsets
`define IVD_VEC_TRAP 8'hfe
`define IVD_VEC_EXT 8'hfa
`define IVD_VEC_DFLT 8'he0
// peripheral slots, highest rank first: f8 f6 f4 f2 ee ec ea e8 e6 e4 e2
`define IVD_SLOT_OFFS 88'hf8_f6_f4_f2_ee_ec_ea_e8_e6_e4_e2
`endif

// File: rtl/ivd_pkg.sv
/*
  types of the interrupt vector dispatch block.
  assumes ivd_cfg.svh holds every number; this package only holds types.
*/
package ivd_pkg;
  // ========================================================================
  // dispatch sequencer states, gray coded along idle -> hi -> lo -> load
  typedef enum logic [1:0] {
    IVD_IDLE = 2'b00,
    IVD_RD_HI = 2'b01,
    IVD_RD_LO = 2'b11,
    IVD_LOAD = 2'b10
  } ivd_state_t;
endpackage : ivd_pkg

// File: verif/ivd_chk.sv
/* checker of the dispatch sequence at the top ports.
   assumes hclk rising edge and hresetn active low. */
`timescale 1ns/100ps
module ivd_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // core side
  input wire logic vector_dispatch_instruction,
  input wire logic [14:0] dispatch_pc,
  input wire logic trap_instruction,
  input wire logic pc_load,
  input wire logic [14:0] pc_value,
  input wire logic dispatch_busy,
  // program memory side
  input wire logic pm_req,
  input wire logic [14:0] pm_addr,
  input wire logic [7:0] pm_rdata,
  input wire logic pm_ack
);
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // keep both vector bytes so the loaded value can be rebuilt
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_r <= 8'h00;
      lo_r <= 8'h00;
    end else if (pm_req && pm_ack) begin
      if (pm_addr[0]) lo_r <= pm_rdata;
      else hi_r <= pm_rdata;
    end
  end
  // ==========
  // assertions
  dispatch_start_a: assert property (vector_dispatch_instruction && !dispatch_busy
    |=> dispatch_busy && pm_req) else $error("dispatch did not start");
  even_offset_a: assert property ($rose(dispatch_busy)
    |-> !pm_addr[0] && pm_addr[7:5] == 3'h7) else $error("offset not even in e0-fe");
  table_block_a: assert property (vector_dispatch_instruction && !dispatch_busy
    |=> pm_addr[14:8] == 7'($past(dispatch_pc[14:8])
    + 7'($past(dispatch_pc[7:0]) == 8'hff))) else $error("wrong table block");
  low_after_high_a: assert property (pm_req && pm_ack && !pm_addr[0]
    |=> pm_req && pm_addr == ($past(pm_addr) | 15'h1)) else $error("low byte read missing");
  load_after_low_a: assert property (pm_req && pm_ack && pm_addr[0]
    |=> !pm_req ##1 pc_load) else $error("pc load late");
  vector_value_a: assert property (pc_load
    |-> pc_value == {hi_r[6:0], lo_r}) else $error("wrong vector loaded");
  addr_hold_a: assert property (pm_req && !pm_ack
    |=> pm_req && $stable(pm_addr)) else $error("read dropped before answer");
  trap_first_a: assert property ($past(trap_instruction) && vector_dispatch_instruction
    && !dispatch_busy |=> pm_addr[7:0] == 8'hfe) else $error("trap not chosen");
endmodule : ivd_chk

// File: verif/ivd_pm.sv
/* program memory model: byte per request, optional wait states.
   assumes the dispatcher holds pm_req and pm_addr until pm_ack. */
`timescale 1ns/100ps
module ivd_pm (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // read port
  input wire logic pm_req,
  input wire logic [14:0] pm_addr,
  input wire logic slow,
  output logic [7:0] pm_rdata,
  output logic pm_ack
);
  logic [1:0] wait_r;
  // data toggles when idle so stale bytes are never mistaken for answers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pm_ack <= 1'b0;
      pm_rdata <= 8'h00;
      wait_r <= 2'h0;
    end else if (pm_ack) begin
      pm_ack <= 1'b0;
      pm_rdata <= ~pm_rdata;
      wait_r <= {slow, 1'b0};
    end else if (pm_req && wait_r == 2'h0) begin
      pm_ack <= 1'b1;
      pm_rdata <= pm_addr[7:0] ^ {pm_addr[14:8], 1'b1} ^ 8'h3c;
    end else begin
      pm_rdata <= ~pm_rdata;
      if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
    end
  end
endmodule : ivd_pm

// File: verif/testbench.sv
/* self-checking bench of the dispatch block.
   assumes ivd_top, ivd_pm and ivd_chk are compiled first. */
`timescale 1ns/100ps
`include "ivd_cfg.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module testbench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dsp, clr_nmi, trap, irt, taken;
  logic pc_load, busy, pm_req, pm_ack, ext_pin, core_int_req, irq, slow;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [31:0] cyc = 32'h0;
  logic [14:0] dpc, pc_value, pm_addr;
  logic [7:0] pm_rdata;
  logic [10:0] pend;
  int err_total, cmp_count;
  ivd_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vector_dispatch_instruction(dsp),
    .dispatch_pc(dpc), .clear_nmi_pending_instruction(clr_nmi), .trap_instruction(trap),
    .interrupt_return_instruction(irt), .int_taken(taken), .pc_load(pc_load),
    .pc_value(pc_value), .dispatch_busy(busy), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .pm_ack(pm_ack), .ext_pin(ext_pin), .periph_pend(pend),
    .core_int_req(core_int_req), .irq(irq));
  ivd_pm u_pm (.hclk(hclk), .hresetn(hresetn), .pm_req(pm_req), .pm_addr(pm_addr),
    .slow(slow), .pm_rdata(pm_rdata), .pm_ack(pm_ack));
  // ==========
  // clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========
  // helpers
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  function automatic logic [7:0] mem(logic [14:0] a);
    return a[7:0] ^ {a[14:8], 1'b1} ^ 8'h3c;
  endfunction : mem
  // lowest rank first so the highest active source wins
  function automatic logic [7:0] exp_off(logic [10:0] p);
    logic [87:0] t;
    t = `IVD_SLOT_OFFS;
    exp_off = `IVD_VEC_DFLT;
    for (int i = 10; i >= 0; i--) if (p[i]) exp_off = t[87-8*i -: 8];
  endfunction : exp_off
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {27'h0, a};
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  // sources change right after the first cycle to prove they are not resampled
  task automatic dispatch(logic [14:0] pc, logic [7:0] off, logic [10:0] nxt);
    logic [6:0] blk;
    logic [7:0] h, l;
    blk = pc[14:8] + 7'(pc[7:0] == 8'hff);
    h = mem({blk, off});
    l = mem({blk, off | 8'h01});
    dsp <= 1'b1;
    dpc <= pc;
    @(posedge hclk);
    dsp <= 1'b0;
    pend <= nxt;
    repeat (40) if (pc_load !== 1'b1) @(posedge hclk);
    `CHK("pc_value", {h[6:0], l}, pc_value)
  endtask : dispatch
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // ==========
  // main sequence
  initial begin
    {hsel, hwrite, dsp, clr_nmi, trap, irt, taken, ext_pin, slow} = 9'h0;
    {htrans, haddr, hwdata, dpc, pend} = 0;
    seed = 32'd39;
    err_total = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) begin
      bus(1'b0, 5'(a), 32'h0);
      `CHK("reset read", 33'h0, {hresp, rd})
    end
    $display("test reset done");
    bus(1'b1, `IVD_OFS_CTRL, 32'h6);
    ext_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    dispatch(15'h00ff, `IVD_VEC_DFLT, pend);
    ext_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    dispatch(15'h12a0, `IVD_VEC_EXT, pend);
    bus(1'b1, `IVD_OFS_PEN, 32'h7ff);
    pend <= 11'h7ff;
    trap <= 1'b1;
    @(posedge hclk);
    trap <= 1'b0;
    dispatch(15'h3456, `IVD_VEC_TRAP, pend);
    clr_nmi <= 1'b1;
    @(posedge hclk);
    clr_nmi <= 1'b0;
    dispatch(15'h3456, `IVD_VEC_EXT, pend);
    bus(1'b1, `IVD_OFS_PEND, 32'h1);
    dispatch(15'h7fff, 8'hf8, pend);
    taken <= 1'b1;
    @(posedge hclk);
    taken <= 1'b0;
    irt <= 1'b1;
    @(posedge hclk);
    irt <= 1'b0;
    bus(1'b0, `IVD_OFS_CTRL, 32'h0);
    `CHK("gie", 1'b1, rd[`IVD_CTRL_GIE])
    `CHK("int req", 1'b1, core_int_req)
    bus(1'b1, `IVD_OFS_CTRL, 32'h4);
    ext_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(1'b0, `IVD_OFS_PEND, 32'h0);
    `CHK("rising pend", 1'b1, rd[`IVD_PEND_EXT])
    bus(1'b1, `IVD_OFS_PEND, 32'h1);
    bus(1'b0, `IVD_OFS_PEND, 32'h0);
    `CHK("pend clear", 1'b0, rd[`IVD_PEND_EXT])
    $display("test priority done");
    for (int n = 0; n < 24; n++) begin
      seed = xs(seed);
      pend <= seed[10:0] & {11{seed[11]}};
      slow <= seed[12];
      @(posedge hclk);
      dispatch({seed[26:20], n % 4 == 0 ? 8'hff : seed[19:12]}, exp_off(pend), ~pend);
    end
    $display("test random done");
    bus(1'b0, `IVD_OFS_STAT, 32'h0);
    `CHK("status", 4'hf, rd[3:0])
    bus(1'b1, `IVD_OFS_MASK, 32'h4);
    @(posedge hclk);
    `CHK("irq on", 1'b1, irq)
    bus(1'b1, `IVD_OFS_STAT, 32'hf);
    @(posedge hclk);
    `CHK("irq off", 1'b0, irq)
    $display("test irq done");
    print_verdict();
  end
endmodule : testbench
bind ivd_top ivd_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .vector_dispatch_instruction(vector_dispatch_instruction), .dispatch_pc(dispatch_pc),
  .trap_instruction(trap_instruction), .pc_load(pc_load), .pc_value(pc_value),
  .dispatch_busy(dispatch_busy), .pm_req(pm_req), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
  .pm_ack(pm_ack));
